/* panel_cfg.svh */
// Purpose: constants for the front-panel status and sync block
// Assumes: 200 MHz pclk
// Notes: byte offsets on APB, one word per register
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH

`define CLK_HZ 200000000
`define REFRESH_MS 1000
`define FLASH_MS 250
`define STRETCH_MS 100

`define OFF_CTRL 12'h000
`define OFF_STAT 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_EN 12'h00C
`define OFF_IRQ_CLR 12'h010
`define OFF_SYNC_DIV 12'h014

`define CTRL_ETHER 0
`define CTRL_LINK_MASTER 1
`define CTRL_SYNC_PRIMARY 2
`define CTRL_RESET 32'h0000_0000

`define SYNC_DIV_RESET 32'h0000_0064

`define IRQ_REFRESH 0
`define IRQ_COLLISION 1
`define IRQ_PKT_ERR 2
`define IRQ_LOCK 3
`define IRQ_W 4

`endif

/* panel_pkg.sv */
// Purpose: types for the front-panel status and sync block
// Assumes: nothing
// Notes: lock state of the radio link
package panel_pkg;
  typedef enum logic [1:0] {LK_IDLE, LK_SEEK, LK_LOCKED} lock_state_t;
endpackage

/* status_panel.sv */
// Operation
// - Pulse a display refresh once every second, without software.
// - Serial: user LED lit while cable attached and DTR asserted.
// - Ethernet: user LED lit while live LAN cable connected.
// - Serial: clock LED lit while user synchronous clock present.
// - Ethernet: clock LED flashes on each detected collision. Here it lights only if the flash phase is high during its 100 ms stretch.
// - Transmit LED lit while user equipment sends data.
// - Receive LED lit while forwarding radio data to user.
// - Error LED flashes when a received packet has an error. Here it lights only if the flash phase is high during its 100 ms stretch.
// - Lock LED flashes red while seeking, steady green when locked.
// - Only the primary unit drives sync clock; others follow it.
// - All chained units transmit together, then receive together. Here followers toggle only on rising chain edges, at half the primary's rate.
// - Both chain sockets behave identically.
// - No lock unless one end master and the other slave.
// - Link master governs tx/rx timing; slave follows it. Here tx_phase comes from the sync primary; link master only gates lock.
//
// Purpose: front-panel LEDs, display refresh and sync chain logic
// Assumes: all inputs synchronous to pclk
// Notes: APB slave, registers in panel_cfg.svh
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "panel_cfg.svh"

module status_panel
  import panel_pkg::*;
#(
  parameter int REFRESH_CYC = `CLK_HZ / 1000 * `REFRESH_MS,
  parameter int FLASH_CYC = `CLK_HZ / 1000 * `FLASH_MS,
  parameter int STRETCH_CYC = `CLK_HZ / 1000 * `STRETCH_MS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // User side
  input wire logic user_cable,
  input wire logic user_dtr,
  input wire logic lan_link,
  input wire logic user_clk_ok,
  input wire logic collision,
  input wire logic user_tx_act,
  input wire logic user_rx_act,
  // Radio side
  input wire logic pkt_err,
  input wire logic modem_sync,
  input wire logic peer_master,
  // Sync chain, two identical sockets
  input wire logic sock_a_in,
  output logic sock_a_out,
  output logic sock_a_oe,
  input wire logic sock_b_in,
  output logic sock_b_out,
  output logic sock_b_oe,
  // Indicators and display
  output logic user_led,
  output logic clock_collision_indicator,
  output logic tx_led,
  output logic rx_led,
  output logic retransmit_error_indicator,
  output logic lock_red,
  output logic lock_green,
  output logic display_refresh,
  // Timing and interrupt
  output logic tx_phase,
  output logic irq
);

  logic [31:0] ctrl_r;
  logic [31:0] sync_div_r;
  logic [`IRQ_W-1:0] irq_stat_r, irq_en_r;
  logic [31:0] refresh_cnt_r;
  logic [31:0] flash_cnt_r;
  logic flash_ph_r;
  logic [31:0] coll_cnt_r, err_cnt_r;
  logic [31:0] phase_cnt_r;
  logic phase_r;
  logic chain_prev_r;
  lock_state_t lock_r, lock_nxt;
  logic wr, rd, ether, primary, chain_in, chain_edge, refresh_tick;

  assign ether = ctrl_r[`CTRL_ETHER];
  assign primary = ctrl_r[`CTRL_SYNC_PRIMARY];
  assign wr = psel & penable & pwrite;
  // Read data loads in setup so it already stands at the access edge
  assign rd = psel & ~penable & ~pwrite;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `OFF_CTRL) || (a == `OFF_STAT) ||
              (a == `OFF_IRQ_STAT) || (a == `OFF_IRQ_EN) ||
              (a == `OFF_IRQ_CLR) || (a == `OFF_SYNC_DIV);
  endfunction

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr && paddr == `OFF_CTRL) begin
      ctrl_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_div_r <= `SYNC_DIV_RESET;
    end else if (wr && paddr == `OFF_SYNC_DIV) begin
      // Zero would stall the cycle counter
      sync_div_r <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= '0;
    end else if (wr && paddr == `OFF_IRQ_EN) begin
      irq_en_r <= pwdata[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      if (paddr == `OFF_CTRL) begin
        prdata <= ctrl_r;
      end else if (paddr == `OFF_STAT) begin
        prdata <= {24'h00_0000, phase_r, lock_green, lock_red, tx_led,
                   rx_led, clock_collision_indicator, user_led,
                   retransmit_error_indicator};
      end else if (paddr == `OFF_IRQ_STAT) begin
        prdata <= {28'h000_0000, irq_stat_r};
      end else if (paddr == `OFF_IRQ_EN) begin
        prdata <= {28'h000_0000, irq_en_r};
      end else if (paddr == `OFF_SYNC_DIV) begin
        prdata <= sync_div_r;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Display refresh and flash timebase
  // ------------------------------------------------------------
  assign refresh_tick = (refresh_cnt_r == REFRESH_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_cnt_r <= 32'h0000_0000;
      display_refresh <= 1'b0;
    end else begin
      refresh_cnt_r <= refresh_tick ? 32'h0000_0000 : refresh_cnt_r + 1;
      display_refresh <= refresh_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_ph_r <= 1'b0;
    end else if (flash_cnt_r == FLASH_CYC - 1) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_ph_r <= ~flash_ph_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 1;
    end
  end

  // ------------------------------------------------------------
  // Event stretchers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_cnt_r <= 32'h0000_0000;
    end else if (collision && ether) begin
      coll_cnt_r <= STRETCH_CYC;
    end else if (coll_cnt_r != 0) begin
      coll_cnt_r <= coll_cnt_r - 1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_r <= 32'h0000_0000;
    end else if (pkt_err) begin
      err_cnt_r <= STRETCH_CYC;
    end else if (err_cnt_r != 0) begin
      err_cnt_r <= err_cnt_r - 1;
    end
  end

  // ------------------------------------------------------------
  // Link lock
  // ------------------------------------------------------------
  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      LK_IDLE: begin
        // Both ends same role never align
        if (ctrl_r[`CTRL_LINK_MASTER] != peer_master) begin
          lock_nxt = LK_SEEK;
        end
      end
      LK_SEEK: begin
        if (ctrl_r[`CTRL_LINK_MASTER] == peer_master) begin
          lock_nxt = LK_IDLE;
        end else if (modem_sync) begin
          lock_nxt = LK_LOCKED;
        end
      end
      default: begin
        if (ctrl_r[`CTRL_LINK_MASTER] == peer_master || !modem_sync) begin
          lock_nxt = LK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= LK_IDLE;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // ------------------------------------------------------------
  // Sync chain and tx/rx cycle
  // ------------------------------------------------------------
  // Either socket may carry the incoming clock
  assign chain_in = sock_a_in | sock_b_in;
  assign chain_edge = chain_in & ~chain_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_prev_r <= 1'b0;
      phase_cnt_r <= 32'h0000_0000;
      phase_r <= 1'b0;
    end else begin
      chain_prev_r <= chain_in;
      if (primary) begin
        if (phase_cnt_r >= sync_div_r - 1) begin
          phase_cnt_r <= 32'h0000_0000;
          phase_r <= ~phase_r;
        end else begin
          phase_cnt_r <= phase_cnt_r + 1;
        end
      end else if (chain_edge) begin
        phase_r <= ~phase_r;
      end
    end
  end

  // Both sockets repeat the same clock
  assign sock_a_out = primary & phase_r;
  assign sock_b_out = primary & phase_r;
  assign sock_a_oe = primary;
  assign sock_b_oe = primary;
  assign tx_phase = phase_r;

  // ------------------------------------------------------------
  // Indicators
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_led <= 1'b0;
      clock_collision_indicator <= 1'b0;
      tx_led <= 1'b0;
      rx_led <= 1'b0;
      retransmit_error_indicator <= 1'b0;
      lock_red <= 1'b0;
      lock_green <= 1'b0;
    end else begin
      user_led <= ether ? lan_link : (user_cable & user_dtr);
      clock_collision_indicator <= ether ? (coll_cnt_r != 0) & flash_ph_r
                                         : user_clk_ok;
      tx_led <= user_tx_act;
      rx_led <= user_rx_act;
      retransmit_error_indicator <= (err_cnt_r != 0) & flash_ph_r;
      lock_red <= (lock_r != LK_LOCKED) & flash_ph_r;
      lock_green <= (lock_r == LK_LOCKED);
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  logic [`IRQ_W-1:0] ev, clr;
  assign ev = {lock_nxt == LK_LOCKED && lock_r != LK_LOCKED,
               pkt_err, collision & ether, refresh_tick};
  assign clr = (wr && paddr == `OFF_IRQ_CLR) ? pwdata[`IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      // Set wins over clear
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_refresh_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    display_refresh |=> !display_refresh) else $error("refresh too long");
  a_user_serial: assert property (@(posedge pclk) disable iff (!presetn)
    !ether && user_cable && user_dtr ##1 !ether |-> user_led)
    else $error("user led off");
  a_user_ether: assert property (@(posedge pclk) disable iff (!presetn)
    ether && lan_link ##1 ether |-> user_led)
    else $error("lan led off");
  a_clock_serial: assert property (@(posedge pclk) disable iff (!presetn)
    !ether && !user_clk_ok |=> !clock_collision_indicator)
    else $error("clock led stray");
  a_tx_follow: assert property (@(posedge pclk) disable iff (!presetn)
    user_tx_act |=> tx_led) else $error("tx led off");
  a_rx_follow: assert property (@(posedge pclk) disable iff (!presetn)
    user_rx_act |=> rx_led) else $error("rx led off");
  a_err_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_err |=> err_cnt_r == STRETCH_CYC) else $error("no stretch");
  a_lock_green: assert property (@(posedge pclk) disable iff (!presetn)
    lock_green |-> !lock_red) else $error("lock both colours");
  a_same_role: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[`CTRL_LINK_MASTER] == peer_master |=> lock_r == LK_IDLE)
    else $error("lock with same role");
  a_follow_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !primary |-> !sock_a_oe && !sock_b_oe) else $error("follower drives");
  a_follow_edge: assert property (@(posedge pclk) disable iff (!presetn)
    !primary && chain_edge |=> phase_r != $past(phase_r))
    else $error("phase missed");
endmodule

/* chain_peer.sv */
// Purpose: neighbour unit acting as primary on the sync chain
// Assumes: runs on pclk
// Notes: line sits low while not driven, as a pull-down would leave it
`timescale 1ns/1ps
module chain_peer #(
  parameter int HALF = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and chain line
  input wire logic drive,
  output logic chain_clk
);
  int cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 0;
      chain_clk <= 1'b0;
    end else if (!drive) begin
      cnt_r <= 0;
      chain_clk <= 1'b0;
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 0;
      chain_clk <= ~chain_clk;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule

/* tb_status_indicator_and_sync_logic.sv */
// Purpose: self-checking bench for the front-panel status block
// Assumes: short refresh, flash and stretch counts
// Notes: read data is taken at the access edge, with pready
`timescale 1ns/1ps
`include "panel_cfg.svh"
module tb_status_indicator_and_sync_logic;
  localparam int REF = 100;
  localparam int FL = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen, ph;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic user_cable, user_dtr, lan_link, user_clk_ok, collision, user_tx_act;
  logic user_rx_act, pkt_err, modem_sync, peer_master, sock_a_in, sock_b_in;
  logic sock_a_out, sock_a_oe, sock_b_out, sock_b_oe, user_led, tx_led;
  logic clock_collision_indicator, retransmit_error_indicator, lock_red;
  logic lock_green, display_refresh, tx_phase, irq, rx_led;
  logic peer_drive, use_a, peer_clk;
  logic [10:0] rows [8];
  int n_errors, n_tests, cnt, k;
  assign sock_a_in = use_a & peer_clk;
  assign sock_b_in = ~use_a & peer_clk;
  status_panel #(.REFRESH_CYC(REF), .FLASH_CYC(FL), .STRETCH_CYC(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .user_cable(user_cable),
    .user_dtr(user_dtr), .lan_link(lan_link), .user_clk_ok(user_clk_ok),
    .collision(collision), .user_tx_act(user_tx_act),
    .user_rx_act(user_rx_act), .pkt_err(pkt_err), .modem_sync(modem_sync),
    .peer_master(peer_master), .sock_a_in(sock_a_in),
    .sock_a_out(sock_a_out), .sock_a_oe(sock_a_oe), .sock_b_in(sock_b_in),
    .sock_b_out(sock_b_out), .sock_b_oe(sock_b_oe), .user_led(user_led),
    .clock_collision_indicator(clock_collision_indicator),
    .tx_led(tx_led), .rx_led(rx_led), .lock_red(lock_red),
    .retransmit_error_indicator(retransmit_error_indicator),
    .lock_green(lock_green), .display_refresh(display_refresh),
    .tx_phase(tx_phase), .irq(irq));
  chain_peer #(.HALF(6)) u_peer (.pclk(pclk), .presetn(presetn),
    .drive(peer_drive), .chain_clk(peer_clk));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (pready !== 1'b1 && cnt < 50);
    check("pready", pready, 1);
    // Taken at the access edge, before that edge's updates land
    err_seen = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ev(input bit sel);
    k = 0;
    ph = tx_phase;
    do begin
      @(negedge pclk);
      k++;
    end while (k < 500 && (sel ? display_refresh !== 1'b1 : tx_phase === ph));
  endtask
  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {user_cable, user_dtr, lan_link, user_clk_ok, collision} = '0;
    {user_tx_act, user_rx_act, pkt_err, modem_sync, peer_master} = '0;
    {peer_drive, use_a} = '0;
    rows = '{11'h308, 11'h222, 11'h191, 11'h044, 11'h488, 11'h740, 11'h433,
             11'h000};
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Ordinary level cases: ether bit, six inputs, four expected LEDs
    foreach (rows[i]) begin
      apb(1, `OFF_CTRL, {31'h0, rows[i][10]});
      {user_cable, user_dtr, lan_link, user_clk_ok, user_tx_act,
       user_rx_act} <= rows[i][9:4];
      repeat (3) @(negedge pclk);
      check("user", user_led, rows[i][3]);
      check("clk", clock_collision_indicator, rows[i][2]);
      check("tx", tx_led, rows[i][1]);
      check("rx", rx_led, rows[i][0]);
    end
    apb(0, `OFF_SYNC_DIV, 0);
    check("div_rst", rd, `SYNC_DIV_RESET);
    apb(0, `OFF_IRQ_EN, 0);
    check("en_rst", rd, 0);
    apb(0, 12'h020, 0);
    check("unmapped_err", err_seen, 1);
    check("unmapped", rd, 0);
    // Events: collision then packet error, masked, enabled, cleared
    apb(1, `OFF_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      apb(1, `OFF_IRQ_CLR, 32'hF);
      collision <= (i == 0);
      pkt_err <= (i == 1);
      @(posedge pclk);
      {collision, pkt_err} <= 2'b00;
      // Flash phase is free running, so count lit cycles in the stretch
      cnt = 0;
      repeat (16) @(negedge pclk) cnt += (i ? retransmit_error_indicator
                                            : clock_collision_indicator);
      check("flash", cnt > 0 && cnt < 16, 1);
      check("irq_mask", irq, 0);
      apb(0, `OFF_IRQ_STAT, 0);
      check("stat", rd & (32'h2 << i), 32'h2 << i);
      apb(1, `OFF_IRQ_EN, 32'h2 << i);
      @(negedge pclk);
      check("irq_on", irq, 1);
      apb(1, `OFF_IRQ_CLR, 32'h2 << i);
      @(negedge pclk);
      check("irq_clr", irq, 0);
      apb(1, `OFF_IRQ_EN, 0);
      repeat (20) @(negedge pclk);
      check("unflash", i ? retransmit_error_indicator
                         : clock_collision_indicator, 0);
    end
    // Lock needs one master and one slave, either way round
    for (int m = 0; m < 2; m++) begin
      apb(1, `OFF_CTRL, {30'h0, m[0], 1'b0});
      peer_master <= m[0];
      modem_sync <= 1'b1;
      repeat (20) @(negedge pclk);
      check("no_lock", lock_green, 0);
      @(posedge pclk);
      peer_master <= ~m[0];
      modem_sync <= 1'b0;
      cnt = 0;
      repeat (4 * FL) @(negedge pclk) cnt += (lock_red === 1'b1);
      check("seek", cnt > 0 && cnt < 4 * FL, 1);
      @(posedge pclk);
      modem_sync <= 1'b1;
      repeat (2 * FL) @(negedge pclk);
      check("lock", {lock_green, lock_red}, 2'b10);
      @(posedge pclk);
      modem_sync <= 1'b0;
    end
    // Follower on either socket
    apb(1, `OFF_CTRL, 0);
    peer_drive <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      @(posedge pclk);
      use_a <= s[0];
      repeat (3) wait_ev(0);
      check("follow", k, 12);
      check("no_drive", {sock_a_oe, sock_b_oe}, 0);
    end
    @(posedge pclk);
    peer_drive <= 1'b0;
    apb(1, `OFF_SYNC_DIV, 0);
    apb(0, `OFF_SYNC_DIV, 0);
    check("div0", rd, 1);
    apb(1, `OFF_SYNC_DIV, 4);
    apb(1, `OFF_CTRL, 32'h4);
    repeat (3) wait_ev(0);
    check("primary", k, 4);
    check("oe", {sock_a_oe, sock_b_oe}, 2'b11);
    check("sock_eq", sock_a_out, sock_b_out);
    wait_ev(1);
    wait_ev(1);
    check("refresh", k, REF);
    // Mid-run reset drops the primary role and restores registers
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    check("rst_oe", {sock_a_oe, sock_b_oe, tx_phase}, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFF_CTRL, 0);
    check("ctrl_rst", rd, `CTRL_RESET);
    apb(0, `OFF_SYNC_DIV, 0);
    check("div_rst2", rd, `SYNC_DIV_RESET);
    apb(0, `OFF_IRQ_STAT, 0);
    check("stat_rst", rd, 0);
    finish_test();
  end
endmodule
